// *** verilog/nax_pkg.sv ***
// Package for the nibble ALU: widths, opcode codes and reset values.
// Assumes one core clock and a surrounding core that fetches and decodes.
package nax_pkg;

   localparam int          NAX_W         = 4;
   localparam logic [3:0]  NAX_ZERO      = 4'h0;
   localparam logic [3:0]  NAX_ONE       = 4'h1;
   localparam logic [3:0]  NAX_SIX       = 4'h6;
   localparam logic [3:0]  NAX_TEN       = 4'ha;
   localparam logic [3:0]  NAX_ALL_ONES  = 4'hf;
   localparam int          NAX_TOP_BIT   = 3;

   // Operation codes presented by the surrounding decoder.
   typedef enum logic [4:0] {
      NAX_OP_NOP         = 5'h00,
      NAX_OP_CLEAR_WREG  = 5'h01,
      NAX_OP_CLEAR_CARRY = 5'h02,
      NAX_OP_SET_CARRY   = 5'h03,
      NAX_OP_INVERT_WREG = 5'h04,
      NAX_OP_WREG_PLUS   = 5'h05,
      NAX_OP_WREG_MINUS  = 5'h06,
      NAX_OP_ROTATE_LEFT = 5'h07,
      NAX_OP_COPY_AUX    = 5'h08,
      NAX_OP_SWAP_AUX    = 5'h09,
      NAX_OP_MEM_PLUS    = 5'h0a,
      NAX_OP_MEM_MINUS   = 5'h0b,
      NAX_OP_SET_BIT     = 5'h0c,
      NAX_OP_CLEAR_BIT   = 5'h0d,
      NAX_OP_ADD         = 5'h0e,
      NAX_OP_ADD_CARRY   = 5'h0f,
      NAX_OP_BCD_SUM     = 5'h10,
      NAX_OP_BCD_SUB     = 5'h11,
      NAX_OP_AND         = 5'h12,
      NAX_OP_OR          = 5'h13,
      NAX_OP_XOR         = 5'h14,
      NAX_OP_CMP_MEM     = 5'h15,
      NAX_OP_CMP_IMM     = 5'h16,
      NAX_OP_CMP_PTR_LOW = 5'h17,
      NAX_OP_LOAD_IMM    = 5'h18
   } nax_op_t;

   // Second-cycle state of the two-cycle pointer compare.
   typedef enum logic [0:0] {
      NAX_ST_IDLE   = 1'b0,
      NAX_ST_SECOND = 1'b1
   } nax_state_t;

endpackage : nax_pkg

// *** verilog/nax_alu.sv ***
// Nibble ALU: executes arithmetic, logic, compare and load-immediate
// operations on the working register, auxiliary register and memory nibble.
// Assumes the core decodes opcodes, supplies the pointer-addressed nibble
// combinationally and writes back mem_wdata when mem_we pulses.
//
// Contract
// - Clear sets wreg to zero, updates zero.
// - Clear/set carry; wreg untouched.
// - Invert complements wreg, updates zero.
// - Wreg plus one updates zero, carry.
// - Wreg minus one updates zero, carry.
// - Rotate left through carry, updates zero.
// - Copy wreg to aux, flags unchanged.
// - Swap wreg and aux, flags unchanged.
// - Memory plus/minus one, written back, flags.
// - Set/clear memory bit; clear updates zero.
// - Add memory to wreg, updates zero, carry.
// - Add memory and carry, updates flags.
// - Add six to wreg, zero only.
// - Add ten to wreg, zero only.
// - AND memory into wreg, updates zero.
// - OR memory into wreg, updates zero.
// - Compare memory, operands unchanged, flags set.
// - Compare immediate against wreg, flags set.
// - Pointer-low compare: two cycles, zero only.
// - Load immediate into wreg, updates zero.
`timescale 1ns/10ps

module nax_alu
   import nax_pkg::*;
#(
   parameter int W = nax_pkg::NAX_W
) (
   // Clock and reset.
   input  wire logic              sys_clk,
   input  wire logic              srst,
   // Instruction issue from the decoder.
   input  wire logic              op_valid,
   input  wire nax_pkg::nax_op_t  op_code,
   input  wire logic [3:0]        op_imm,
   input  wire logic [1:0]        op_bit_sel,
   output logic                   op_ready,
   // Memory nibble and pointer.
   input  wire logic [3:0]        mem_rdata,
   input  wire logic [3:0]        pointer_low_nibble,
   output logic [3:0]             mem_wdata,
   output logic                   mem_we,
   // Architectural state.
   output logic [3:0]             wreg,
   output logic [3:0]             aux_reg,
   output logic                   carry_flag,
   output logic                   zero_flag
);
   import nax_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Zero test used by every zero-flag update except the clear, which sets the flag outright.
   function automatic logic nax_is_zero(input logic [3:0] v);
      return (v == NAX_ZERO);
   endfunction : nax_is_zero

   // Five-bit sum; the top bit is the carry out.
   function automatic logic [4:0] nax_sum(input logic [3:0] a, input logic [3:0] b,
                                          input logic cin);
      return {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction : nax_sum

   // Compare carry: low only where the memory or immediate operand is the
   // larger one, which is the opposite sense of a plain borrow.
   function automatic logic nax_cmp_carry(input logic [3:0] a, input logic [3:0] w);
      return !(a > w);
   endfunction : nax_cmp_carry

   // Compare zero: the low four bits of a plus the inverted w plus one vanish
   // only when the two operands are equal.
   function automatic logic nax_cmp_zero(input logic [3:0] a, input logic [3:0] w);
      logic [4:0] d;
      d = nax_sum(a, ~w, 1'b1);
      return nax_is_zero(d[3:0]);
   endfunction : nax_cmp_zero

   // ---------------------------------------------------------------
   // Registers and next values
   // ---------------------------------------------------------------
   // Each register except ptr_imm_q pairs with its next value; s and r are scratch results
   // that only the decode process writes.
   logic [3:0]  wreg_q, wreg_d;
   logic [3:0]  aux_q, aux_d;
   logic        carry_q, carry_d;
   logic        zero_q, zero_d;
   logic [3:0]  mem_wdata_q, mem_wdata_d;
   logic        mem_we_q, mem_we_d;
   nax_state_t  state_q, state_d;
   logic [3:0]  ptr_imm_q;
   logic [4:0]  s;
   logic [3:0]  r;

   // ---------------------------------------------------------------
   // Execution decode
   // ---------------------------------------------------------------

   // An op is taken at the rising edge where op_valid and op_ready are both
   // high; its results land in the registers at that edge and show one cycle
   // after issue. The memory nibble is read combinationally in the issue
   // cycle, and the write-back leaves through a registered port a cycle later,
   // so the core must keep the data pointer still until that pulse has gone.
   // Codes with no branch below, the no-op among them, leave every register alone except ptr_imm_q, which loads op_imm, and mem_we, which drops low.
   // Default holds every register except mem_we, which defaults low; each operation overrides only what it owns.
   always_comb begin
      wreg_d      = wreg_q;
      aux_d       = aux_q;
      carry_d     = carry_q;
      zero_d      = zero_q;
      mem_wdata_d = mem_wdata_q;
      mem_we_d    = 1'b0;
      state_d     = state_q;
      // Scratch values start at zero so no latch can form on any path.
      s           = 5'h00;
      r           = NAX_ZERO;
      if (state_q == NAX_ST_SECOND) begin
         // Second cycle of the pointer compare: only zero changes.
         // Any op offered now is refused, because op_ready is low.
         zero_d  = nax_is_zero(pointer_low_nibble ^ ptr_imm_q);
         state_d = NAX_ST_IDLE;
      end else if (op_valid) begin
         case (op_code)
            NAX_OP_CLEAR_WREG: begin
               // The result is known to be zero, so the flag is set outright.
               wreg_d = NAX_ZERO;
               zero_d = 1'b1;
            end
            NAX_OP_CLEAR_CARRY: begin
               // Only the carry moves; wreg and zero stay put.
               carry_d = 1'b0;
            end
            NAX_OP_SET_CARRY: begin
               // Only the carry moves; wreg and zero stay put.
               carry_d = 1'b1;
            end
            NAX_OP_INVERT_WREG: begin
               // Ones' complement; the carry is not touched.
               r      = ~wreg_q;
               wreg_d = r;
               zero_d = nax_is_zero(r);
            end
            NAX_OP_WREG_PLUS: begin
               // Carry out of bit three is the overflow.
               s       = nax_sum(wreg_q, NAX_ONE, 1'b0);
               wreg_d  = s[3:0];
               zero_d  = nax_is_zero(s[3:0]);
               carry_d = s[4];
            end
            NAX_OP_WREG_MINUS: begin
               // Adding all ones subtracts one; carry out low means a borrow.
               s       = nax_sum(wreg_q, NAX_ALL_ONES, 1'b0);
               wreg_d  = s[3:0];
               zero_d  = nax_is_zero(s[3:0]);
               carry_d = s[4];
            end
            NAX_OP_ROTATE_LEFT: begin
               // Old carry enters bit zero; the old top bit leaves into carry.
               r       = {wreg_q[NAX_TOP_BIT-1:0], carry_q};
               wreg_d  = r;
               carry_d = wreg_q[NAX_TOP_BIT];
               zero_d  = nax_is_zero(r);
            end
            NAX_OP_COPY_AUX: begin
               // Pure transfer: no flag reflects the copied value.
               aux_d = wreg_q;
            end
            NAX_OP_SWAP_AUX: begin
               // Both sides read the old values, so one edge does the exchange.
               aux_d  = wreg_q;
               wreg_d = aux_q;
            end
            NAX_OP_MEM_PLUS: begin
               // The nibble is rewritten through the registered write port.
               s           = nax_sum(mem_rdata, NAX_ONE, 1'b0);
               mem_wdata_d = s[3:0];
               mem_we_d    = 1'b1;
               zero_d      = nax_is_zero(s[3:0]);
               carry_d     = s[4];
            end
            NAX_OP_MEM_MINUS: begin
               s           = nax_sum(mem_rdata, NAX_ALL_ONES, 1'b0);
               mem_wdata_d = s[3:0];
               mem_we_d    = 1'b1;
               zero_d      = nax_is_zero(s[3:0]);
               carry_d     = s[4];
            end
            NAX_OP_SET_BIT: begin
               // Zero is left alone here; only the clearing form updates it.
               r              = mem_rdata;
               r[op_bit_sel]  = 1'b1;
               mem_wdata_d    = r;
               mem_we_d       = 1'b1;
            end
            NAX_OP_CLEAR_BIT: begin
               // Zero reflects the whole rewritten nibble, not just the bit.
               r              = mem_rdata;
               r[op_bit_sel]  = 1'b0;
               mem_wdata_d    = r;
               mem_we_d       = 1'b1;
               zero_d         = nax_is_zero(r);
            end
            NAX_OP_ADD: begin
               // Plain binary sum; the incoming carry is ignored.
               s       = nax_sum(wreg_q, mem_rdata, 1'b0);
               wreg_d  = s[3:0];
               zero_d  = nax_is_zero(s[3:0]);
               carry_d = s[4];
            end
            NAX_OP_ADD_CARRY: begin
               // The incoming carry joins as the sum's carry-in.
               s       = nax_sum(wreg_q, mem_rdata, carry_q);
               wreg_d  = s[3:0];
               zero_d  = nax_is_zero(s[3:0]);
               carry_d = s[4];
            end
            NAX_OP_BCD_SUM: begin
               // Carry is deliberately left alone; software tests it first.
               s      = nax_sum(wreg_q, NAX_SIX, 1'b0);
               wreg_d = s[3:0];
               zero_d = nax_is_zero(s[3:0]);
            end
            NAX_OP_BCD_SUB: begin
               // Adding ten is subtracting six modulo sixteen; carry stays.
               s      = nax_sum(wreg_q, NAX_TEN, 1'b0);
               wreg_d = s[3:0];
               zero_d = nax_is_zero(s[3:0]);
            end
            NAX_OP_AND: begin
               r      = wreg_q & mem_rdata;
               wreg_d = r;
               zero_d = nax_is_zero(r);
            end
            NAX_OP_OR: begin
               r      = wreg_q | mem_rdata;
               wreg_d = r;
               zero_d = nax_is_zero(r);
            end
            NAX_OP_XOR: begin
               // Exclusive-or companion of the two logic ops above.
               r      = wreg_q ^ mem_rdata;
               wreg_d = r;
               zero_d = nax_is_zero(r);
            end
            NAX_OP_CMP_MEM: begin
               // Both operands stay as they are; only the two flags move.
               carry_d = nax_cmp_carry(mem_rdata, wreg_q);
               zero_d  = nax_cmp_zero(mem_rdata, wreg_q);
            end
            NAX_OP_CMP_IMM: begin
               // Same convention, with the immediate in the memory operand's place.
               carry_d = nax_cmp_carry(op_imm, wreg_q);
               zero_d  = nax_cmp_zero(op_imm, wreg_q);
            end
            NAX_OP_CMP_PTR_LOW: begin
               // Cycle one only arms the compare; the zero flag moves in cycle two.
               state_d = NAX_ST_SECOND;
            end
            NAX_OP_LOAD_IMM: begin
               // The immediate is loaded as is; the carry is not touched.
               wreg_d = op_imm;
               zero_d = nax_is_zero(op_imm);
            end
            default: begin
               wreg_d = wreg_q;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------

   // Working and auxiliary registers.
   // Reset clears both, so a swap right after reset moves zeros.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wreg_q <= NAX_ZERO;
         aux_q  <= NAX_ZERO;
      end else begin
         wreg_q <= wreg_d;
         aux_q  <= aux_d;
      end
   end

   // Status flags. Both reset low; zero then follows results only, so it
   // is not forced to match the cleared wreg after reset.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         carry_q <= 1'b0;
         zero_q  <= 1'b0;
      end else begin
         carry_q <= carry_d;
         zero_q  <= zero_d;
      end
   end

   // Memory write-back port.
   // The write pulse lasts one cycle because its next value defaults low.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mem_wdata_q <= NAX_ZERO;
         mem_we_q    <= 1'b0;
      end else begin
         mem_wdata_q <= mem_wdata_d;
         mem_we_q    <= mem_we_d;
      end
   end

   // Two-cycle pointer compare sequencing; one bit of state is all it needs.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q <= NAX_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Immediate held for cycle two. It loads on every op taken while idle,
   // which costs a little power but keeps the load term to one condition.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ptr_imm_q <= NAX_ZERO;
      end else if (op_valid && state_q == NAX_ST_IDLE) begin
         ptr_imm_q <= op_imm;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Ready comes straight from the state register, so it is free of glitches
   // and the decoder can simply hold its next op through cycle two.
   assign op_ready   = (state_q == NAX_ST_IDLE);
   assign mem_wdata  = mem_wdata_q;
   assign mem_we     = mem_we_q;
   assign wreg       = wreg_q;
   assign aux_reg    = aux_q;
   assign carry_flag = carry_q;
   assign zero_flag  = zero_q;

endmodule : nax_alu

// *** bench/nax_alu_props.sv ***
// Port-level assertions and covers for the nibble ALU.
// Assumes one clock, a synchronous active-high reset, ops taken on valid and ready.
`timescale 1ns/10ps
module nax_alu_props
   import nax_pkg::*;
#(
   parameter int W = nax_pkg::NAX_W
) (
   // Clock and reset.
   input wire logic              sys_clk,
   input wire logic              srst,
   // Issue side.
   input wire logic              op_valid,
   input wire nax_pkg::nax_op_t  op_code,
   input wire logic [3:0]        op_imm,
   input wire logic [1:0]        op_bit_sel,
   input wire logic              op_ready,
   // Memory side.
   input wire logic [3:0]        mem_rdata,
   input wire logic [3:0]        pointer_low_nibble,
   input wire logic [3:0]        mem_wdata,
   input wire logic              mem_we,
   // Architectural state.
   input wire logic [3:0]        wreg,
   input wire logic [3:0]        aux_reg,
   input wire logic              carry_flag,
   input wire logic              zero_flag
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   // An op counts only where the block is ready, so refused ops trigger nothing.
   logic take;
   assign take = op_valid && op_ready;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   a_clear_wreg: assert property (take && op_code == NAX_OP_CLEAR_WREG
      |=> wreg == 4'h0 && zero_flag) else $error("clear left wreg or zero wrong");
   a_set_carry: assert property (take && op_code == NAX_OP_SET_CARRY
      |=> carry_flag && $stable(wreg)) else $error("set carry failed");
   a_invert_wreg: assert property (take && op_code == NAX_OP_INVERT_WREG
      |=> wreg == ~$past(wreg)) else $error("invert result wrong");
   a_rotate_left: assert property (take && op_code == NAX_OP_ROTATE_LEFT
      |=> {carry_flag, wreg} == {$past(wreg), $past(carry_flag)}) else $error("rotate wrong");
   a_copy_aux: assert property (take && op_code == NAX_OP_COPY_AUX
      |=> aux_reg == $past(wreg) && $stable(wreg) && $stable(carry_flag) && $stable(zero_flag))
      else $error("copy to aux wrong");
   a_swap_regs: assert property (take && op_code == NAX_OP_SWAP_AUX
      |=> wreg == $past(aux_reg) && aux_reg == $past(wreg) && $stable(zero_flag)
      && $stable(carry_flag)) else $error("swap wrong");
   a_mem_plus: assert property (take && op_code == NAX_OP_MEM_PLUS
      |=> mem_we && mem_wdata == $past(mem_rdata) + 4'h1) else $error("memory increment wrong");
   a_add_sum: assert property (take && op_code == NAX_OP_ADD
      |=> {carry_flag, wreg} == {1'b0, $past(wreg)} + {1'b0, $past(mem_rdata)})
      else $error("add result wrong");
   a_bcd_sum: assert property (take && op_code == NAX_OP_BCD_SUM
      |=> wreg == $past(wreg) + 4'h6 && $stable(carry_flag)) else $error("adjust by six wrong");
   a_ptr_two_cycle: assert property (take && op_code == NAX_OP_CMP_PTR_LOW
      |=> !op_ready ##1 op_ready && zero_flag == ($past(pointer_low_nibble) == $past(op_imm, 2)))
      else $error("pointer compare timing or zero wrong");
   a_load_zero: assert property (take && op_code == NAX_OP_LOAD_IMM
      |=> wreg == $past(op_imm) && zero_flag == (wreg == 4'h0)) else $error("load wrong");
   c_ptr_cmp: cover property (take && op_code == NAX_OP_CMP_PTR_LOW);
   c_mem_write: cover property (mem_we);
   c_swap: cover property (take && op_code == NAX_OP_SWAP_AUX);
endmodule : nax_alu_props

bind nax_alu nax_alu_props #(.W(W)) i_props (.sys_clk(sys_clk), .srst(srst),
   .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm), .op_bit_sel(op_bit_sel),
   .op_ready(op_ready), .mem_rdata(mem_rdata), .pointer_low_nibble(pointer_low_nibble),
   .mem_wdata(mem_wdata), .mem_we(mem_we), .wreg(wreg), .aux_reg(aux_reg),
   .carry_flag(carry_flag), .zero_flag(zero_flag));

// *** bench/tb_nibble_alu_instruction_execution.sv ***
// Directed testbench for the nibble ALU with a small reference model.
// Assumes results show just after the taking edge, where each check samples them.
`timescale 1ns/10ps
module tb_nibble_alu_instruction_execution;
   import nax_pkg::*;
   // ---------------------------------------------------------------
   // Signals, model state and clock
   // ---------------------------------------------------------------
   logic       sys_clk = 1'b0;
   logic       srst = 1'b1;
   logic       op_valid = 1'b0;
   nax_op_t    op_code = NAX_OP_NOP;
   logic [3:0] op_imm = 4'h0;
   logic [1:0] op_bit_sel = 2'h0;
   logic [3:0] mem_rdata = 4'h0;
   logic [3:0] pointer_low_nibble = 4'h0;
   logic       op_ready, mem_we, carry_flag, zero_flag;
   logic [3:0] mem_wdata, wreg, aux_reg;
   logic [3:0] ew = 4'h0, ea = 4'h0;
   logic       ec = 1'b0, ez = 1'b0;
   int         fail_count = 0;
   int         checks = 0;
   always #4 sys_clk = ~sys_clk;
   nax_alu i_dut (.sys_clk(sys_clk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
      .op_imm(op_imm), .op_bit_sel(op_bit_sel), .op_ready(op_ready), .mem_rdata(mem_rdata),
      .pointer_low_nibble(pointer_low_nibble), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .wreg(wreg), .aux_reg(aux_reg), .carry_flag(carry_flag), .zero_flag(zero_flag));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic chk_state(input logic we, input logic [3:0] wd);
      chk("wreg", ew, wreg);
      chk("aux_reg", ea, aux_reg);
      chk("carry_zero", {2'h0, ec, ez}, {2'h0, carry_flag, zero_flag});
      chk("mem_we", {3'h0, we}, {3'h0, mem_we});
      if (we) chk("mem_wdata", wd, mem_wdata);
   endtask : chk_state
   // Leaves op_valid high so the next op can follow back to back.
   task automatic step(input nax_op_t op, input logic [3:0] m = 4'h0,
                       input logic [3:0] imm = 4'h0, input logic [1:0] sel = 2'h0);
      logic [3:0] r;
      r = m;
      case (op)
         NAX_OP_CLEAR_WREG:  ew = 4'h0;
         NAX_OP_CLEAR_CARRY: ec = 1'b0;
         NAX_OP_SET_CARRY:   ec = 1'b1;
         NAX_OP_INVERT_WREG: ew = ~ew;
         NAX_OP_WREG_PLUS:   {ec, ew} = {1'b0, ew} + 5'h01;
         NAX_OP_WREG_MINUS:  {ec, ew} = {ew != 4'h0, ew - 4'h1};
         NAX_OP_ROTATE_LEFT: {ec, ew} = {ew, ec};
         NAX_OP_COPY_AUX:    ea = ew;
         NAX_OP_SWAP_AUX:    {ew, ea} = {ea, ew};
         NAX_OP_MEM_PLUS:    {ec, r} = {1'b0, m} + 5'h01;
         NAX_OP_MEM_MINUS:   {ec, r} = {m != 4'h0, m - 4'h1};
         NAX_OP_SET_BIT:     r = m | (4'h1 << sel);
         NAX_OP_CLEAR_BIT:   r = m & ~(4'h1 << sel);
         NAX_OP_ADD:         {ec, ew} = {1'b0, ew} + {1'b0, m};
         NAX_OP_ADD_CARRY:   {ec, ew} = {1'b0, ew} + {1'b0, m} + {4'h0, ec};
         NAX_OP_BCD_SUM:     ew = ew + NAX_SIX;
         NAX_OP_BCD_SUB:     ew = ew + NAX_TEN;
         NAX_OP_AND:         ew = ew & m;
         NAX_OP_OR:          ew = ew | m;
         NAX_OP_XOR:         ew = ew ^ m;
         NAX_OP_CMP_MEM:     {ec, ez} = {m <= ew, m == ew};
         NAX_OP_CMP_IMM:     {ec, ez} = {imm <= ew, imm == ew};
         NAX_OP_LOAD_IMM:    ew = imm;
         default:            ;
      endcase
      if (op inside {NAX_OP_MEM_PLUS, NAX_OP_MEM_MINUS, NAX_OP_CLEAR_BIT}) ez = (r == 4'h0);
      else if (!(op inside {NAX_OP_CLEAR_CARRY, NAX_OP_SET_CARRY, NAX_OP_COPY_AUX,
         NAX_OP_SWAP_AUX, NAX_OP_SET_BIT, NAX_OP_CMP_MEM, NAX_OP_CMP_IMM})) ez = (ew == 4'h0);
      op_valid = 1'b1;
      op_code = op;
      mem_rdata = m;
      op_imm = imm;
      op_bit_sel = sel;
      @(posedge sys_clk);
      #1;
      chk_state(op inside {[NAX_OP_MEM_PLUS:NAX_OP_CLEAR_BIT]}, r);
   endtask : step
   task automatic idle;
      op_valid = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : idle
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_flags;
      step(NAX_OP_LOAD_IMM, 4'h0, 4'h5);
      step(NAX_OP_SET_CARRY);
      step(NAX_OP_INVERT_WREG);
      step(NAX_OP_CLEAR_CARRY);
      step(NAX_OP_CLEAR_WREG);
      step(NAX_OP_INVERT_WREG);
      step(NAX_OP_WREG_PLUS);
      step(NAX_OP_WREG_MINUS);
      step(NAX_OP_WREG_MINUS);
      step(NAX_OP_LOAD_IMM, 4'h0, 4'h9);
      repeat (4) step(NAX_OP_ROTATE_LEFT);
      step(NAX_OP_COPY_AUX);
      step(NAX_OP_LOAD_IMM, 4'h0, 4'h3);
      repeat (2) step(NAX_OP_SWAP_AUX);
      idle();
   endtask : t_flags
   task automatic t_mem;
      step(NAX_OP_MEM_PLUS, 4'hf);
      step(NAX_OP_MEM_MINUS, 4'h0);
      step(NAX_OP_MEM_MINUS, 4'h1);
      for (int i = 0; i < 4; i++) begin
         step(NAX_OP_SET_BIT, 4'h0, 4'h0, 2'(i));
         step(NAX_OP_CLEAR_BIT, 4'h1 << i, 4'h0, 2'(i));
         step(NAX_OP_CLEAR_BIT, 4'hf, 4'h0, 2'(i));
      end
      idle();
   endtask : t_mem
   task automatic t_arith;
      step(NAX_OP_LOAD_IMM, 4'h0, 4'h9);
      step(NAX_OP_ADD, 4'h7);
      step(NAX_OP_ADD_CARRY, 4'h4);
      step(NAX_OP_ADD_CARRY, 4'hb);
      step(NAX_OP_BCD_SUM);
      step(NAX_OP_BCD_SUB);
      step(NAX_OP_LOAD_IMM, 4'h0, 4'h6);
      step(NAX_OP_AND, 4'h9);
      step(NAX_OP_OR, 4'h9);
      step(NAX_OP_XOR, 4'h9);
      step(NAX_OP_LOAD_IMM, 4'h0, 4'h7);
      for (int i = 6; i < 9; i++) begin
         step(NAX_OP_CMP_MEM, 4'(i));
         step(NAX_OP_CMP_IMM, 4'h0, 4'(i));
      end
      idle();
   endtask : t_arith
   // A clear sent while the block is busy must be refused.
   task automatic t_ptr(input logic [3:0] p, input logic [3:0] imm);
      pointer_low_nibble = p;
      op_valid = 1'b1;
      op_code = NAX_OP_CMP_PTR_LOW;
      op_imm = imm;
      @(posedge sys_clk);
      #1;
      op_code = NAX_OP_CLEAR_WREG;
      chk("op_ready", 4'h0, {3'h0, op_ready});
      @(posedge sys_clk);
      #1;
      op_valid = 1'b0;
      ez = (p == imm);
      chk_state(1'b0, 4'h0);
      chk("op_ready", 4'h1, {3'h0, op_ready});
      @(posedge sys_clk);
      #1;
   endtask : t_ptr
   task automatic summarize;
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      #20000;
      fail_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      chk_state(1'b0, 4'h0);
      chk("op_ready", 4'h1, {3'h0, op_ready});
      t_flags();
      t_mem();
      t_arith();
      t_ptr(4'h3, 4'h3);
      t_ptr(4'h3, 4'h4);
      summarize();
   end
endmodule : tb_nibble_alu_instruction_execution
